// ### pia_port.sv
`default_nettype none

// Notes on behaviour
// - Master drives bit clock and WS
// - Sixteen-bit channel words, 32-bit stereo frame
// - MSB launched one bit after WS edge
// - WS low left, WS high right
// - Launch on falling, capture on rising edge
// - Master stereo rates 1411.2 or 1536 kHz
// - Slave accepts bit clocks to 3.072 MHz
// - Stereo and voice share one port
// - Voice master drives clock and sync
// - Reset framing is stereo compatible
// - Slot count follows interface rate
// - Three channels mapped onto voice slots
// - Channel transmit and receive share slot
// - Data driver released on unused slots
// - Release after last bit falling edge
// - Short sync one bit, high pulse
// - Short slave: sync at fall, slot zero next
// - Long sync three bits from slot start
// - Thirteen of sixteen bits carry speech
// - Unused bits ignored in, filled out
// - Default left justified, zero fill, MSB first
// - Burst mode runs port at top rate
module pia_port
    import pia_pkg::*;
#(
    parameter int unsigned LINK_CLK_HZ = LINK_CLK_HZ_DEF
) (
    input  wire logic       clk,       // System clock
    input  wire logic       rstn,      // Async reset, active low
    input  wire logic       link_clk,  // Port reference clock
    input  wire pia_cfg_t   cfg,       // Port configuration
    input  wire logic       tx_valid,  // Transmit frame offered
    input  wire pia_frame_t tx_frame,  // Transmit channel words
    output logic            tx_ready,  // Holding register empty
    output logic            rx_valid,  // Receive frame pulse
    output pia_frame_t      rx_frame,  // Receive channel words
    output logic            busy,      // Port running
    output logic            underrun,  // Frame sent without data
    input  wire logic       bclk_i,    // Bit clock pin in
    output logic            bclk_o,    // Bit clock pin out
    output logic            bclk_oe,   // Bit clock drive enable
    input  wire logic       ws_i,      // WS or sync pin in
    output logic            ws_o,      // WS or sync pin out
    output logic            ws_oe,     // WS or sync drive enable
    input  wire logic       din,       // Serial data in
    output logic            dout,      // Serial data out
    output logic            dout_oe    // Serial data drive enable
);

    // ------------------------------------------------------------------
    // Divider constants
    // ------------------------------------------------------------------
    function automatic int unsigned hc(input int unsigned hz);
        int unsigned h;
        h = LINK_CLK_HZ / (2 * hz);
        // Two-flop din sync needs three per half
        return (h < 3) ? 3 : h;
    endfunction

    localparam int unsigned HALF_441   = hc(I2S_BCLK_441_HZ);
    localparam int unsigned HALF_48    = hc(I2S_BCLK_48_HZ);
    localparam int unsigned HALF_BURST = hc(BURST_BCLK_MAX_HZ);
    localparam int unsigned HALF_V [0:4] = '{hc(VOICE_BCLK_BASE_HZ), hc(VOICE_BCLK_BASE_HZ * 2),
                                             hc(VOICE_BCLK_BASE_HZ * 4), hc(VOICE_BCLK_BASE_HZ * 8),
                                             hc(VOICE_BCLK_BASE_HZ * 16)};

    // Slave edges are found by oversampling, so the reference must be fast enough
    if (LINK_CLK_HZ < SLAVE_OVERSAMPLE * SLAVE_BCLK_MAX_HZ) begin : g_chk_rate
        $error("LINK_CLK_HZ too slow for slave bit clock");
    end
    if (LINK_CLK_HZ / (2 * VOICE_BCLK_BASE_HZ) > 65535) begin : g_chk_div
        $error("LINK_CLK_HZ too fast for 16-bit divider");
    end

    function automatic logic [WORD_W-1:0] rev(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] o;
        o = '0;
        for (int i = 0; i < WORD_W; i++) begin
            o[i] = w[WORD_W-1-i];
        end
        return o;
    endfunction

    function automatic logic [WORD_W-1:0] fmt(input logic [WORD_W-1:0] w, input pia_cfg_t c);
        logic [FILL_W-1:0] f;
        logic [WORD_W-1:0] o;
        unique case (c.fill)
            FILL_ZERO: f = '0;
            FILL_ONE:  f = '1;
            FILL_SIGN: f = {FILL_W{w[SAMP_W-1]}};
            FILL_PROG: f = c.fill_val;
        endcase
        o = c.right_just ? {f, w[SAMP_W-1:0]} : {w[SAMP_W-1:0], f};
        return c.lsb_first ? rev(o) : o;
    endfunction

    function automatic logic [WORD_W-1:0] unfmt(input logic [WORD_W-1:0] w, input pia_cfg_t c);
        logic [WORD_W-1:0] o;
        logic [SAMP_W-1:0] s;
        o = c.lsb_first ? rev(w) : w;
        s = c.right_just ? o[SAMP_W-1:0] : o[WORD_W-1:FILL_W];
        return {{FILL_W{s[SAMP_W-1]}}, s};
    endfunction

    // ------------------------------------------------------------------
    // Link domain reset and input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] lrst_q;
    logic       lrstn;

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end
    assign lrstn = lrst_q[1];

    pia_cfg_t   cfg_s1_q;
    pia_cfg_t   cfg_s2_q;
    logic [2:0] bclk_sy_q;
    logic [1:0] ws_sy_q;
    logic [1:0] din_sy_q;

    // Config is only sampled into use while idle, so per-bit skew is harmless
    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            cfg_s1_q  <= CFG_RST;
            cfg_s2_q  <= CFG_RST;
            bclk_sy_q <= 3'h0;
            ws_sy_q   <= 2'h0;
            din_sy_q  <= 2'h0;
        end else begin
            cfg_s1_q  <= cfg;
            cfg_s2_q  <= cfg_s1_q;
            bclk_sy_q <= {bclk_sy_q[1:0], bclk_i};
            ws_sy_q   <= {ws_sy_q[0], ws_i};
            din_sy_q  <= {din_sy_q[0], din};
        end
    end

    // ------------------------------------------------------------------
    // Port state and active configuration
    // ------------------------------------------------------------------
    pia_lstate_t      state_q;
    pia_cfg_t         acfg_q;
    logic             lrun_q;
    logic             locked_q;
    logic             lock_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] lastc;
    logic [2:0]       vr;
    logic             i2s_fr;
    logic             short_mode;
    logic             rise_ev;
    logic             fall_ev;
    logic             edge_hit;
    logic             wsr_q;
    logic [15:0]      div_q;
    logic [15:0]      half;
    logic             m_tick;
    logic             bclk_q;

    // Voice with WS framing is the stereo-compatible form
    assign i2s_fr     = !acfg_q.voice || acfg_q.sync == SYNC_WS;
    assign short_mode = !i2s_fr && acfg_q.sync == SYNC_SHORT;
    assign vr         = (acfg_q.vrate > 3'(VRATE_MAX)) ? 3'(VRATE_MAX) : acfg_q.vrate;
    assign lastc      = i2s_fr ? CNT_W'(I2S_FRAME_BITS - 1)
                               : CNT_W'((WORD_W << vr) - 1);
    assign cnt_next   = (cnt_q >= lastc) ? '0 : CNT_W'(cnt_q + 1'b1);

    always_comb begin
        if (acfg_q.burst) begin
            half = 16'(HALF_BURST);
        end else if (!acfg_q.voice) begin
            half = acfg_q.rate48 ? 16'(HALF_48) : 16'(HALF_441);
        end else begin
            half = 16'(HALF_V[vr]);
        end
    end

    assign m_tick  = div_q == half - 16'h1;
    assign rise_ev = lrun_q && (acfg_q.master ? (m_tick && !bclk_q) : (bclk_sy_q[1] && !bclk_sy_q[2]));
    assign fall_ev = lrun_q && (acfg_q.master ? (m_tick && bclk_q) : (!bclk_sy_q[1] && bclk_sy_q[2]));
    assign edge_hit = !short_mode && (i2s_fr ? (wsr_q && !ws_sy_q[1]) : (!wsr_q && ws_sy_q[1]));

    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            state_q <= L_IDLE;
            lrun_q  <= 1'b0;
            acfg_q  <= CFG_RST;
        end else begin
            unique case (state_q)
                L_IDLE: begin
                    acfg_q <= cfg_s2_q;
                    if (cfg_s2_q.en) begin
                        state_q <= L_RUN;
                        lrun_q  <= 1'b1;
                    end
                end
                L_RUN: begin
                    if (!cfg_s2_q.en && ((fall_ev && cnt_q >= lastc) || !locked_q)) begin
                        state_q <= L_IDLE;
                        lrun_q  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bit clock generation and frame position
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            div_q  <= 16'h0;
            bclk_q <= 1'b0;
        end else if (!lrun_q || !acfg_q.master) begin
            div_q  <= 16'h0;
            bclk_q <= 1'b0;
        end else if (m_tick) begin
            div_q  <= 16'h0;
            bclk_q <= !bclk_q;
        end else begin
            div_q  <= div_q + 16'h1;
        end
    end

    always_comb begin
        cnt_d  = cnt_q;
        lock_d = locked_q;
        if (!lrun_q) begin
            cnt_d  = '1;
            lock_d = 1'b0;
        end else if (acfg_q.master) begin
            lock_d = 1'b1;
            if (fall_ev) begin
                cnt_d = cnt_next;
            end
        end else if (fall_ev) begin
            if (short_mode && ws_sy_q[1]) begin
                cnt_d  = '0;
                lock_d = 1'b1;
            end else begin
                cnt_d  = cnt_next;
            end
        end else if (rise_ev && edge_hit) begin
            cnt_d  = '0;
            lock_d = 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            cnt_q    <= '1;
            locked_q <= 1'b0;
            wsr_q    <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            locked_q <= lock_d;
            if (rise_ev) begin
                wsr_q <= ws_sy_q[1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers for clock and word select
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            ws_o    <= 1'b0;
            ws_oe   <= 1'b0;
            bclk_oe <= 1'b0;
        end else begin
            bclk_oe <= lrun_q && acfg_q.master;
            ws_oe   <= lrun_q && acfg_q.master;
            if (!lrun_q || !acfg_q.master) begin
                ws_o <= 1'b0;
            end else if (short_mode) begin
                if (rise_ev) begin
                    ws_o <= cnt_q == lastc;
                end
            end else if (fall_ev) begin
                ws_o <= i2s_fr ? (cnt_d >= CNT_W'(I2S_FRAME_BITS / 2))
                               : (cnt_d < CNT_W'(LONG_SYNC_BITS));
            end
        end
    end
    assign bclk_o = bclk_q;

    // ------------------------------------------------------------------
    // Transmit serializer
    // ------------------------------------------------------------------
    pia_frame_t        txf_q;
    pia_frame_t        tx_x_q;
    logic [WORD_W-1:0] sh_q;
    logic [WORD_W-1:0] slot_word;
    logic              slot_hit;
    logic              load;
    logic              frame_done;
    logic              fr_tgl_q;

    always_comb begin
        slot_hit  = 1'b0;
        slot_word = '0;
        load      = 1'b0;
        if (i2s_fr) begin
            slot_hit = 1'b1;
            if (cnt_d == CNT_W'(I2S_LEFT_LOAD)) begin
                load      = 1'b1;
                slot_word = txf_q.ch[0];
            end else if (cnt_d == CNT_W'(I2S_RIGHT_LOAD)) begin
                load      = 1'b1;
                slot_word = txf_q.ch[1];
            end
        end else begin
            load = cnt_d[3:0] == 4'h0;
            for (int k = 0; k < NCH; k++) begin
                if (!slot_hit && acfg_q.ch_en[k] && acfg_q.ch_slot[k] == cnt_d[7:4]) begin
                    slot_hit  = 1'b1;
                    slot_word = txf_q.ch[k];
                end
            end
        end
        if (acfg_q.voice) begin
            slot_word = fmt(slot_word, acfg_q);
        end
    end

    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            sh_q    <= '0;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else if (!lrun_q || !lock_d) begin
            sh_q    <= '0;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else if (fall_ev) begin
            if (load) begin
                sh_q <= slot_word;
                dout <= slot_word[WORD_W-1];
            end else begin
                sh_q <= {sh_q[WORD_W-2:0], 1'b0};
                dout <= sh_q[WORD_W-2];
            end
            // Released at the fall that closes the last bit of a driven slot
            if (i2s_fr || load) begin
                dout_oe <= slot_hit;
            end
        end
    end

    assign frame_done = rise_ev && locked_q &&
                        (i2s_fr ? cnt_q == CNT_W'(I2S_RIGHT_DONE) : cnt_q == lastc);

    // Frame copy is taken a frame after the system side posted it
    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            txf_q    <= '0;
            fr_tgl_q <= 1'b0;
        end else if (frame_done) begin
            txf_q    <= tx_x_q;
            fr_tgl_q <= !fr_tgl_q;
        end
    end

    // ------------------------------------------------------------------
    // Receive deserializer
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] rsh_q;
    logic [WORD_W-1:0] rword;
    logic [WORD_W-1:0] rxw_q [NCH];

    assign rword = {rsh_q[WORD_W-2:0], din_sy_q[1]};

    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            rsh_q <= '0;
        end else if (rise_ev) begin
            rsh_q <= rword;
        end
    end

    for (genvar k = 0; k < NCH; k++) begin : g_rx
        logic hit;
        always_comb begin
            hit = 1'b0;
            if (i2s_fr) begin
                hit = (k == 0 && cnt_q == CNT_W'(I2S_LEFT_DONE)) ||
                      (k == 1 && cnt_q == CNT_W'(I2S_RIGHT_DONE));
            end else begin
                hit = acfg_q.ch_en[k] && cnt_q[3:0] == 4'hf &&
                      acfg_q.ch_slot[k] == cnt_q[7:4];
            end
        end
        always_ff @(posedge link_clk or negedge lrstn) begin
            if (!lrstn) begin
                rxw_q[k] <= '0;
            end else if (rise_ev && locked_q && hit) begin
                rxw_q[k] <= acfg_q.voice ? unfmt(rword, acfg_q) : rword;
            end
        end
    end

    // ------------------------------------------------------------------
    // System domain side
    // ------------------------------------------------------------------
    logic [2:0] tgl_sy_q;
    logic [1:0] run_sy_q;
    logic       ev;
    logic       full_q;
    logic       full_d;
    logic       push;
    pia_frame_t txh_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tgl_sy_q <= 3'h0;
            run_sy_q <= 2'h0;
        end else begin
            tgl_sy_q <= {tgl_sy_q[1:0], fr_tgl_q};
            run_sy_q <= {run_sy_q[0], lrun_q};
        end
    end

    assign ev   = tgl_sy_q[1] ^ tgl_sy_q[2];
    assign push = tx_valid && tx_ready;

    always_comb begin
        full_d = full_q;
        if (ev) begin
            full_d = 1'b0;
        end
        if (push) begin
            full_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            full_q   <= 1'b0;
            tx_ready <= 1'b0;
            txh_q    <= '0;
        end else begin
            full_q   <= full_d;
            tx_ready <= !full_d;
            if (push) begin
                txh_q <= tx_frame;
            end
        end
    end

    // Receive words stay put for at least one 16-bit slot after the toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_x_q   <= '0;
            rx_frame <= '0;
            rx_valid <= 1'b0;
            underrun <= 1'b0;
            busy     <= 1'b0;
        end else begin
            busy     <= run_sy_q[1];
            rx_valid <= ev;
            underrun <= ev && !full_q;
            if (ev) begin
                tx_x_q <= full_q ? txh_q : '0;
                for (int k = 0; k < NCH; k++) begin
                    rx_frame.ch[k] <= rxw_q[k];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### pia_pkg.sv
`default_nettype none

package pia_pkg;

    // ------------------------------------------------------------------
    // Widths and framing
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W         = 16;
    localparam int unsigned SAMP_W         = 13;
    localparam int unsigned FILL_W         = 3;
    localparam int unsigned NCH            = 3;
    localparam int unsigned SLOT_W         = 4;
    localparam int unsigned CNT_W          = 8;
    localparam int unsigned VRATE_MAX      = 4;
    localparam int unsigned I2S_FRAME_BITS = 32;
    localparam int unsigned I2S_LEFT_LOAD  = 1;
    localparam int unsigned I2S_RIGHT_LOAD = 17;
    localparam int unsigned I2S_LEFT_DONE  = 16;
    localparam int unsigned I2S_RIGHT_DONE = 0;
    localparam int unsigned LONG_SYNC_BITS = 3;

    // ------------------------------------------------------------------
    // Bit clock rates
    // ------------------------------------------------------------------
    localparam int unsigned I2S_BCLK_441_HZ    = 1411200;
    localparam int unsigned I2S_BCLK_48_HZ     = 1536000;
    localparam int unsigned VOICE_BCLK_BASE_HZ = 128000;
    localparam int unsigned SLAVE_BCLK_MAX_HZ  = 3072000;
    localparam int unsigned BURST_BCLK_MAX_HZ  = 24000000;
    localparam int unsigned SLAVE_OVERSAMPLE   = 4;
    localparam int unsigned LINK_CLK_HZ_DEF    = 33333333;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_PROG} pia_fill_t;
    typedef enum logic [1:0] {SYNC_WS, SYNC_SHORT, SYNC_LONG} pia_sync_t;
    typedef enum logic {L_IDLE, L_RUN} pia_lstate_t;

    typedef struct packed {
        logic                       en;
        logic                       voice;
        logic                       master;
        logic                       burst;
        logic                       rate48;
        logic [2:0]                 vrate;
        pia_sync_t                  sync;
        logic                       right_just;
        logic                       lsb_first;
        pia_fill_t                  fill;
        logic [FILL_W-1:0]          fill_val;
        logic [NCH-1:0]             ch_en;
        logic [NCH-1:0][SLOT_W-1:0] ch_slot;
    } pia_cfg_t;

    typedef struct packed {
        logic [NCH-1:0][WORD_W-1:0] ch;
    } pia_frame_t;

    // Idle stereo-compatible framing, 13-bit left justified, zero fill, MSB first
    localparam pia_cfg_t CFG_RST = '0;

endpackage

`default_nettype wire

// ### pia_port_sva.sv
`default_nettype none
// ----
// Pin timing checks
// ----
module pia_port_sva
    import pia_pkg::*;
(
    input wire logic     clk,      // System clock
    input wire logic     rstn,     // Reset, active low
    input wire logic     link_clk, // Pin clock
    input wire pia_cfg_t cfg,      // Configuration
    input wire logic     rx_valid, // Receive pulse
    input wire logic     busy,     // Port running
    input wire logic     bclk_o,   // Clock out
    input wire logic     bclk_oe,  // Clock drive
    input wire logic     ws_o,     // Sync out
    input wire logic     ws_oe,    // Sync drive
    input wire logic     dout,     // Data out
    input wire logic     dout_oe   // Data drive
);
    timeunit 1ns;
    timeprecision 1ps;
    sequence s_short;
        $rose(bclk_o) ##1 ws_o [*5] ##1 !ws_o;
    endsequence
    sequence s_long;
        $fell(bclk_o) ##1 ws_o [*8] ##1 ws_o [*8] ##1 ws_o ##1 !ws_o;
    endsequence
    AST_SLAVE_QUIET: assert property (@(posedge link_clk) disable iff (!rstn)
        (!cfg.master) [*6] |-> !bclk_oe && !ws_oe) else $error("slave drives pins");
    AST_CLK_WITH_SYNC: assert property (@(posedge link_clk) disable iff (!rstn)
        $rose(bclk_oe) |-> ws_oe) else $error("clock driven without sync");
    AST_DATA_FALL: assert property (@(posedge link_clk) disable iff (!rstn)
        bclk_oe && dout_oe && $past(dout_oe) && $changed(dout) |-> $fell(bclk_o))
        else $error("data moved off a falling edge");
    AST_WS_FALL: assert property (@(posedge link_clk) disable iff (!rstn)
        cfg.sync == SYNC_WS && ws_oe && $past(ws_oe) && $changed(ws_o) |-> $fell(bclk_o))
        else $error("word select moved off a falling edge");
    AST_SHORT_SYNC: assert property (@(posedge link_clk) disable iff (!rstn)
        cfg.voice && cfg.burst && cfg.sync == SYNC_SHORT && ws_oe && $rose(ws_o) |-> s_short)
        else $error("short sync not one bit wide");
    AST_LONG_SYNC: assert property (@(posedge link_clk) disable iff (!rstn)
        cfg.voice && cfg.burst && cfg.sync == SYNC_LONG && ws_oe && $rose(ws_o) |-> s_long)
        else $error("long sync not three bits wide");
    AST_RELEASE_FALL: assert property (@(posedge link_clk) disable iff (!rstn)
        cfg.en && bclk_oe && $fell(dout_oe) |-> $fell(bclk_o)) else $error("release off a fall");
    AST_BURST_RATE: assert property (@(posedge link_clk) disable iff (!rstn)
        (cfg.en && cfg.burst && busy && bclk_oe) [*4] |-> bclk_o != $past(bclk_o, 3))
        else $error("burst clock stalled");
    AST_RX_ONCE: assert property (@(posedge clk) disable iff (!rstn)
        rx_valid |=> !rx_valid) else $error("receive pulse too long");
endmodule
bind pia_port pia_port_sva i_sva (.clk(clk), .rstn(rstn), .link_clk(link_clk), .cfg(cfg),
    .rx_valid(rx_valid), .busy(busy), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .ws_o(ws_o),
    .ws_oe(ws_oe), .dout(dout), .dout_oe(dout_oe));
`default_nettype wire

// ### pia_codec_model.sv
`default_nettype none
// ----
// Codec on the far side
// ----
module pia_codec_model (
    input  wire logic short_sync, // Short sync framing
    input  wire logic bclk,       // Bit clock
    input  wire logic ws,         // WS or sync
    input  wire logic dout,       // Data from port
    output logic      din         // Data to port
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PAT = 16'hb3a5;
    logic [15:0] words [16];
    logic [15:0] sr   = '0;
    logic [7:0]  cnt  = '0;
    logic        ws_r = 1'b0;
    initial din = 1'b0;
    // WS moves on falls, short sync on rises: each is read on the other edge
    always @(posedge bclk) begin
        sr = {sr[14:0], dout};
        if (!short_sync) begin
            if (ws != ws_r)
                words[ws ? 0 : 1] = sr;
            cnt  = (ws != ws_r) ? 8'h00 : cnt + 8'h01;
            ws_r = ws;
        end else if (cnt[3:0] == 4'hf)
            words[cnt[7:4]] = sr;
    end
    always @(negedge bclk) begin
        if (short_sync)
            cnt = ws ? 8'h00 : cnt + 8'h01;
        din <= PAT[4'hf - cnt[3:0]];
    end
endmodule
`default_nettype wire

// ### pia_port_bench.sv
`default_nettype none
module pia_port_bench
    import pia_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Clocks, pins and port
    // ----
    logic       clk      = 1'b0;
    logic       lclk     = 1'b0;
    logic       rstn     = 1'b0;
    logic       tx_valid = 1'b0;
    pia_cfg_t   cfg      = CFG_RST;
    pia_frame_t txf      = '0;
    pia_frame_t rxf;
    logic       tx_ready, rx_valid, busy, bclk_o, bclk_oe, ws_o, ws_oe, dout, dout_oe, din, undr;
    wire logic  bclk     = bclk_oe & bclk_o;
    wire logic  ws       = ws_oe & ws_o;
    wire logic  dln      = dout_oe ? dout : ~dout;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    int         n_under    = 0;
    always #10 clk = ~clk;
    always @(negedge clk) n_under += int'(undr === 1'b1);
    initial begin
        #4;
        forever #15 lclk = ~lclk;
    end
    pia_port i_dut (.clk(clk), .rstn(rstn), .link_clk(lclk), .cfg(cfg), .tx_valid(tx_valid),
        .tx_frame(txf), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rxf), .busy(busy),
        .underrun(undr), .bclk_i(bclk), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .ws_i(ws), .ws_o(ws_o),
        .ws_oe(ws_oe), .din(din), .dout(dout), .dout_oe(dout_oe));
    pia_codec_model i_codec (.short_sync(cfg.sync == SYNC_SHORT), .bclk(bclk), .ws(ws),
        .dout(dln), .din(din));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Stop, reconfigure while idle, start, let frames pass
    task automatic run(input pia_cfg_t c);
        int i;
        int k;
        cfg.en = 1'b0;
        for (i = 0; i < 5000 && busy !== 1'b0; i++)
            @(negedge clk);
        cfg = c;
        repeat (4) @(negedge clk);
        cfg.en = 1'b1;
        k = (busy === 1'b0) ? 0 : -9000;
        for (i = 0; i < 9000 && k < 5; i++) begin
            @(negedge clk);
            k += int'(rx_valid === 1'b1);
        end
        if (k < 5) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    task automatic bit_period(output logic [15:0] p);
        realtime t;
        logic    b;
        int      e;
        t = 0;
        b = 1'b1;
        e = 0;
        p = '0;
        for (int i = 0; i < 100 && e < 2; i++) begin
            @(negedge lclk);
            if (bclk_o && !b) begin
                p = 16'(int'($realtime - t));
                t = $realtime;
                e++;
            end
            b = bclk_o;
        end
    endtask
    initial begin
        pia_cfg_t    c;
        logic [15:0] p, r, e;
        logic [12:0] s;
        static logic [2:0]  fx [4] = '{3'h0, 3'h7, 3'h7, 3'h5};
        static int          sl [3] = '{2, 0, 3};
        repeat (5) @(negedge clk);
        chk({15'h0, tx_ready | dout_oe | bclk_oe}, 16'h0);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        tx_valid = 1'b1;
        txf.ch = {16'h0000, 16'h3c5a, 16'ha5c3};
        for (int k = 0; k < 2; k++) begin
            c = CFG_RST;
            c.master = 1'b1;
            c.rate48 = k[0];
            run(c);
            bit_period(p);
            chk(p, 16'(60 * (LINK_CLK_HZ_DEF / (2 * (k ? I2S_BCLK_48_HZ : I2S_BCLK_441_HZ)))));
            chk(i_codec.words[0], txf.ch[0]);
            chk(i_codec.words[1], txf.ch[1]);
            chk(rxf.ch[0], 16'hb3a5);
            chk(rxf.ch[1], 16'hb3a5);
            $display("stereo run done, rate select %0d", k);
        end
        txf.ch = {16'h1123, 16'h1fff, 16'h1abc};
        for (int f = 0; f < 4; f++) begin
            c = CFG_RST;
            c.master = 1'b1;
            c.voice = 1'b1;
            c.burst = 1'b1;
            c.vrate = 3'd2;
            c.sync = SYNC_SHORT;
            c.fill = pia_fill_t'(f);
            c.fill_val = 3'h5;
            c.right_just = (f == 2);
            c.lsb_first = (f == 3);
            c.ch_en = 3'b111;
            c.ch_slot = {4'h3, 4'h0, 4'h2};
            run(c);
            r = 16'hb3a5;
            if (c.lsb_first)
                r = {<<{r}};
            s = c.right_just ? r[12:0] : r[15:3];
            for (int k = 0; k < 3; k++) begin
                e = c.right_just ? {fx[f], txf.ch[k][12:0]} : {txf.ch[k][12:0], fx[f]};
                if (c.lsb_first)
                    e = {<<{e}};
                chk(i_codec.words[sl[k]], e);
                chk(rxf.ch[k], {{3{s[12]}}, s});
            end
            $display("voice run done, fill %0d", f);
        end
        chk(16'(n_under), 16'h0);
        tx_valid = 1'b0;
        c.sync = SYNC_LONG;
        run(c);
        chk({15'h0, n_under > 2}, 16'h1);
        $display("long sync run done");
        wrap_up();
    end
endmodule
`default_nettype wire
